/* File: core/lsf_pkg.sv */
// Shared constants for the limit status flag logic
`default_nettype none

package lsf_pkg;

    // ==========================================================
    // Register map of the monitor (word addresses)
    // ==========================================================
    localparam logic [7:0] LSF_STATUS_OFS = 8'h02;
    localparam logic [7:0] LSF_POWER_RES_OFS = 8'h06;
    localparam logic [7:0] LSF_LOCAL_RES_OFS = 8'h08;
    localparam logic [7:0] LSF_REM1_RES_OFS = 8'h09;
    localparam logic [7:0] LSF_REM2_RES_OFS = 8'h0a;
    localparam logic [7:0] LSF_REM3_RES_OFS = 8'h0b;
    localparam logic [7:0] LSF_POWER_LIM_OFS = 8'h10;
    localparam logic [7:0] LSF_LOCAL_LIM_OFS = 8'h11;
    localparam logic [7:0] LSF_REM1_LIM_OFS = 8'h12;
    localparam logic [7:0] LSF_REM2_LIM_OFS = 8'h13;
    localparam logic [7:0] LSF_REM3_LIM_OFS = 8'h14;

    // ==========================================================
    // Status word layout
    // ==========================================================
    localparam int LSF_STATUS_W = 16;
    localparam int LSF_POWER_BIT = 11;
    localparam int LSF_LOCAL_BIT = 10;
    localparam int LSF_REM1_BIT = 9;
    localparam int LSF_REM2_BIT = 8;
    localparam int LSF_REM3_BIT = 7;
    localparam logic [15:0] LSF_STATUS_RST = 16'h0000;
    localparam logic LSF_FLAG_RST = 1'b0;

    // ==========================================================
    // Default widths and variant
    // ==========================================================
    localparam int LSF_DATA_W = 16;
    localparam int LSF_NUM_REMOTE = 3;

endpackage : lsf_pkg

`default_nettype wire

/* File: core/lsf_top.sv */
// Over-limit status flags for power, local and remote temperatures
//
// Notes on behaviour
// - Power flag sets when power exceeds limit
// - Local flag sets above limit plus half-hysteresis
// - Transparent: local clears below limit minus half
// - Remote 1 sets above limit plus half-hysteresis
// - Remote 1 also sets on open diode
// - Transparent: remote 1 clears below band, no open
// - Remote 2 sets above limit plus half-hysteresis
// - Remote 2 also sets on open diode
// - Transparent: remote 2 clears below band, no open
// - Remote 3 sets only on three-channel variant
// - Remote 3 also sets on open diode
// - Transparent: remote 3 clears below band, no open
// - Latch mode: flags hold until status read
// - After read, still violated sets at next end
`default_nettype none

module lsf_top
    import lsf_pkg::*;
#(
    parameter int W = LSF_DATA_W,
    parameter int NUM_REMOTE = LSF_NUM_REMOTE
) (
    input wire logic clk_sys,
    input wire logic reset,
    // Alert mode: 1 latch, 0 transparent
    input wire logic latch_mode,
    // Temperature hysteresis, full band width
    input wire logic [W-1:0] temp_hyst,
    // Host read of the status register, one cycle
    input wire logic status_rd,
    // Power channel, unsigned
    input wire logic [W-1:0] power_result,
    input wire logic [W-1:0] power_limit,
    input wire logic power_done,
    // Local temperature, two's complement
    input wire logic [W-1:0] local_result,
    input wire logic [W-1:0] local_limit,
    input wire logic local_done,
    // Remote channel 1
    input wire logic [W-1:0] remote1_result,
    input wire logic [W-1:0] remote1_limit,
    input wire logic remote1_done,
    input wire logic remote1_open,
    // Remote channel 2
    input wire logic [W-1:0] remote2_result,
    input wire logic [W-1:0] remote2_limit,
    input wire logic remote2_done,
    input wire logic remote2_open,
    // Remote channel 3
    input wire logic [W-1:0] remote3_result,
    input wire logic [W-1:0] remote3_limit,
    input wire logic remote3_done,
    input wire logic remote3_open,
    // Status word and individual flags
    output logic [LSF_STATUS_W-1:0] status_word,
    output logic power_over_limit_flag,
    output logic local_temp_over_flag,
    output logic remote_ch1_over_flag,
    output logic remote_ch2_over_flag,
    output logic remote_ch3_over_flag
);

    // ==========================================================
    // Comparison helpers
    // ==========================================================

    // Extended by one bit so limit plus half-band cannot wrap
    function automatic logic signed [W:0] sext(
        input logic [W-1:0] v
    );
        sext = $signed({v[W-1], v});
    endfunction : sext

    function automatic logic signed [W:0] half_band(
        input logic [W-1:0] h
    );
        half_band = $signed({2'b00, h[W-1:1]});
    endfunction : half_band

    function automatic logic temp_above(
        input logic [W-1:0] res,
        input logic [W-1:0] lim,
        input logic [W-1:0] h
    );
        temp_above = sext(res) > (sext(lim) + half_band(h));
    endfunction : temp_above

    function automatic logic temp_below(
        input logic [W-1:0] res,
        input logic [W-1:0] lim,
        input logic [W-1:0] h
    );
        temp_below = sext(res) < (sext(lim) - half_band(h));
    endfunction : temp_below

    // Set beats a same-cycle read clear; inside the band a transparent-mode flag holds
    function automatic logic flag_next(
        input logic q,
        input logic done,
        input logic set_c,
        input logic clr_c,
        input logic latch,
        input logic rd
    );
        if (done && set_c) begin
            flag_next = 1'b1;
        end else if (latch) begin
            flag_next = rd ? 1'b0 : q;
        end else if (done && clr_c) begin
            flag_next = 1'b0;
        end else begin
            flag_next = q;
        end
    endfunction : flag_next

    // ==========================================================
    // Set and clear conditions
    // ==========================================================
    logic pwr_set;
    logic pwr_clr;
    logic loc_set;
    logic loc_clr;
    logic rm1_set;
    logic rm1_clr;
    logic rm2_set;
    logic rm2_clr;
    logic rm3_set;
    logic rm3_clr;
    logic rm3_present;

    assign pwr_set = power_result > power_limit;
    // Transparent power flag drops once the excess is gone
    assign pwr_clr = !pwr_set;

    assign loc_set = temp_above(local_result, local_limit, temp_hyst);
    assign loc_clr = temp_below(local_result, local_limit, temp_hyst);

    assign rm1_set = temp_above(remote1_result, remote1_limit, temp_hyst)
                     || remote1_open;
    assign rm1_clr = temp_below(remote1_result, remote1_limit, temp_hyst)
                     && !remote1_open;

    assign rm2_set = temp_above(remote2_result, remote2_limit, temp_hyst)
                     || remote2_open;
    assign rm2_clr = temp_below(remote2_result, remote2_limit, temp_hyst)
                     && !remote2_open;

    // Two-channel variant keeps the third flag at zero
    assign rm3_present = (NUM_REMOTE >= 3);
    assign rm3_set = rm3_present
                     && (temp_above(remote3_result, remote3_limit, temp_hyst)
                         || remote3_open);
    assign rm3_clr = temp_below(remote3_result, remote3_limit, temp_hyst)
                     && !remote3_open;

    // ==========================================================
    // Next values
    // ==========================================================
    logic pwr_d;
    logic loc_d;
    logic rm1_d;
    logic rm2_d;
    logic rm3_d;

    // Set and transparent clear need the channel's own done strobe; a latch-mode read clears without it
    assign pwr_d = flag_next(power_over_limit_flag, power_done, pwr_set,
                             pwr_clr, latch_mode, status_rd);
    assign loc_d = flag_next(local_temp_over_flag, local_done, loc_set,
                             loc_clr, latch_mode, status_rd);
    assign rm1_d = flag_next(remote_ch1_over_flag, remote1_done, rm1_set,
                             rm1_clr, latch_mode, status_rd);
    assign rm2_d = flag_next(remote_ch2_over_flag, remote2_done, rm2_set,
                             rm2_clr, latch_mode, status_rd);
    assign rm3_d = rm3_present
                   && flag_next(remote_ch3_over_flag, remote3_done, rm3_set,
                                rm3_clr, latch_mode, status_rd);

    // ==========================================================
    // Flag registers
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            power_over_limit_flag <= LSF_FLAG_RST;
            local_temp_over_flag <= LSF_FLAG_RST;
            remote_ch1_over_flag <= LSF_FLAG_RST;
            remote_ch2_over_flag <= LSF_FLAG_RST;
            remote_ch3_over_flag <= LSF_FLAG_RST;
        end else begin
            power_over_limit_flag <= pwr_d;
            local_temp_over_flag <= loc_d;
            remote_ch1_over_flag <= rm1_d;
            remote_ch2_over_flag <= rm2_d;
            remote_ch3_over_flag <= rm3_d;
        end
    end

    // Status word is a registered copy so a read sees one snapshot
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_word <= LSF_STATUS_RST;
        end else begin
            status_word <= LSF_STATUS_RST;
            status_word[LSF_POWER_BIT] <= pwr_d;
            status_word[LSF_LOCAL_BIT] <= loc_d;
            status_word[LSF_REM1_BIT] <= rm1_d;
            status_word[LSF_REM2_BIT] <= rm2_d;
            status_word[LSF_REM3_BIT] <= rm3_d;
        end
    end

endmodule : lsf_top

`default_nettype wire

/* File: verification/lsf_checker.sv */
// Concurrent checks on the power and local flags
`default_nettype none
module lsf_checker
    import lsf_pkg::*;
#(parameter int W = LSF_DATA_W) (
    input wire logic clk_sys, reset, latch_mode, status_rd, power_done, local_done,
    input wire logic [W-1:0] temp_hyst, power_result, power_limit, local_result, local_limit,
    input wire logic power_over_limit_flag, local_temp_over_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    // One bit wider so the band edges never wrap
    wire signed [W:0] hh = $signed({1'b0, temp_hyst[W-1:1]});
    wire signed [W:0] lr = $signed({local_result[W-1], local_result});
    wire signed [W:0] ll = $signed({local_limit[W-1], local_limit});
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_power_set: assert property (power_done && power_result > power_limit
        |=> power_over_limit_flag) else $error("power flag missed");
    a_local_set: assert property (local_done && lr > ll + hh
        |=> local_temp_over_flag) else $error("local flag missed");
    a_local_clear: assert property (!latch_mode && local_done && lr < ll - hh
        |=> !local_temp_over_flag) else $error("local flag stuck");
    a_band_hold: assert property (!latch_mode && local_done
        && lr <= ll + hh && lr >= ll - hh |=> $stable(local_temp_over_flag))
        else $error("local flag moved in band");
    a_latch_clear: assert property (latch_mode && status_rd && !power_done
        |=> !power_over_limit_flag) else $error("read did not clear");
    a_latch_hold: assert property (latch_mode && !status_rd
        |=> !$fell(power_over_limit_flag)) else $error("latched flag fell");
    a_power_hold: assert property (!power_done && !status_rd
        |=> $stable(power_over_limit_flag)) else $error("power flag moved");
    a_local_hold: assert property (!local_done && !status_rd
        |=> $stable(local_temp_over_flag)) else $error("local flag moved");
endmodule : lsf_checker
bind lsf_top lsf_checker #(.W(W)) u_chk (.*);
`default_nettype wire

/* File: verification/lsf_host_model.sv */
// Host side: turns a read request into a one-cycle status read
`default_nettype none
module lsf_host_model (
    input wire logic clk_sys, reset, rd_req,
    output logic status_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    // A serial read takes many cycles, so reads never come back to back
    always_ff @(posedge clk_sys) status_rd <= !reset && rd_req && !status_rd;
endmodule : lsf_host_model
`default_nettype wire

/* File: verification/tb_lsf_top.sv */
// Directed test of the limit status flags
`default_nettype none
module tb_lsf_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, reset = 1, latch_mode = 0, rd_req = 0, status_rd;
    logic [15:0] hyst = 16'h0008, lim_p = 16'h0100, lim_t = 16'h0040, status_word;
    logic [15:0] res [6] = '{default: 16'h0000};
    logic [5:0] done = 6'h00, open = 6'h00;
    logic [4:0] flg;
    int bad_count = 0, comparisons = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    lsf_top u_dut (.clk_sys(clk_sys), .reset(reset), .latch_mode(latch_mode),
        .temp_hyst(hyst), .status_rd(status_rd), .power_result(res[0]), .power_limit(lim_p),
        .power_done(done[0]), .local_result(res[1]), .local_limit(lim_t),
        .local_done(done[1]), .remote1_result(res[2]), .remote1_limit(lim_t),
        .remote1_done(done[2]), .remote1_open(open[2]), .remote2_result(res[3]),
        .remote2_limit(lim_t), .remote2_done(done[3]), .remote2_open(open[3]),
        .remote3_result(res[4]), .remote3_limit(lim_t), .remote3_done(done[4]),
        .remote3_open(open[4]), .status_word(status_word), .power_over_limit_flag(flg[4]),
        .local_temp_over_flag(flg[3]), .remote_ch1_over_flag(flg[2]),
        .remote_ch2_over_flag(flg[1]), .remote_ch3_over_flag(flg[0]));
    lsf_host_model u_host (.clk_sys(clk_sys), .reset(reset), .rd_req(rd_req),
        .status_rd(status_rd));
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Channel 5 is a dummy: only waits, so the pending read clears the flags
    task automatic cc(input int c, input logic [15:0] r, input logic o, input logic [15:0] exp);
        res[c] = r;
        open[c] = o;
        done[c] = 1'b1;
        tick;
        done[c] = 1'b0;
        tick;
        check("status_word", status_word, exp);
        check("flag_outputs", {11'h000, flg}, {11'h000, exp[11:7]});
    endtask : cc
    task automatic rd;
        rd_req = 1'b1;
        tick;
        rd_req = 1'b0;
    endtask : rd
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 1000) bad_count++;
        if (cyc == 1000) test_done;
    end
    initial begin
        repeat (10) tick;
        reset = 1'b0;
        cc(0, 16'h0101, 0, 16'h0800);
        cc(0, 16'h0100, 0, 16'h0000);
        cc(1, 16'h0044, 0, 16'h0000);
        cc(1, 16'h0045, 0, 16'h0400);
        cc(1, 16'h003c, 0, 16'h0400);
        cc(1, 16'h003b, 0, 16'h0000);
        for (int c = 2; c < 5; c++) begin
            cc(c, 16'h0045, 0, 16'h0800 >> c);
            cc(c, 16'h0000, 1, 16'h0800 >> c);
            cc(c, 16'h0000, 0, 16'h0000);
        end
        latch_mode = 1'b1;
        cc(0, 16'h0101, 0, 16'h0800);
        cc(2, 16'h0000, 1, 16'h0a00);
        cc(2, 16'h0000, 0, 16'h0a00);
        rd;
        cc(2, 16'h0000, 1, 16'h0200);
        rd;
        cc(5, 16'h0000, 0, 16'h0000);
        cc(2, 16'h0000, 1, 16'h0200);
        test_done;
    end
endmodule : tb_lsf_top
`default_nettype wire
